// File: inc/glitch_filter_params.svh
// Constants for the N-sample glitch filter.
// Assumes inclusion by the filter package, its module, the line model and the bench.
`ifndef GLITCH_FILTER_PARAMS_SVH
`define GLITCH_FILTER_PARAMS_SVH

// Number of parallel input lines
`define GF_WIDTH 4
// Previous samples that must agree with the current one
`define GF_DEPTH 2
// Reset level of output and history
`define GF_RESET_LEVEL 1'h0
// Clock period in ns; one clock period is one sample_interval
`define GF_SAMPLE_INTERVAL_NS 40

`endif

// File: inc/glitch_filter_pkg.sv
// Types for the N-sample glitch filter.
// Assumes the constants header is on the include path.
`include "glitch_filter_params.svh"

package glitch_filter_pkg;

	typedef logic [`GF_DEPTH-1:0] history_t;

	typedef struct packed {
		logic [`GF_WIDTH-1:0] sync1;
		logic [`GF_WIDTH-1:0] sync2;
		history_t [`GF_WIDTH-1:0] hist;
		logic [`GF_WIDTH-1:0] filtOut;
	} filter_state_t;

endpackage

// File: rtl/glitch_filter_n_sample.sv
// N-sample glitch filter, one lane per input bit.
// Assumes asynchronous raw inputs, resynchronised here before sampling.
//
// Functional notes
// - High needs current and previous N samples all high; low likewise.
// - Disagreeing samples leave the output at its held value.
// - Sustained change shows after N to N plus one sample periods.
// - Every clock edge is one sample; clock period is the sample_interval.
// - Reset forces output and history to zero.
// - Width parameter sets parallel lanes, one output bit per input bit.
// - History depth N is a build-time constant, usually 1, 2 or 3.
`include "glitch_filter_params.svh"

module glitch_filter_n_sample
	import glitch_filter_pkg::*;
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// Raw lines
	input  wire logic [`GF_WIDTH-1:0] rawIn,
	// Cleaned lines
	output logic      [`GF_WIDTH-1:0] filtOut
);

	filter_state_t state_r;
	filter_state_t state_nxt;

	// output latency
	// Latency counted from the synchronised sample, so pin-to-output
	// delay is two cycles longer than N to N plus one.
	logic [`GF_WIDTH-1:0] allHigh;
	logic [`GF_WIDTH-1:0] allLow;

	genvar g;
	generate
		for (g = 0; g < `GF_WIDTH; g++) begin : gLane
			assign allHigh[g] = state_r.sync2[g] & (&state_r.hist[g]);
			assign allLow[g]  = ~state_r.sync2[g] & ~(|state_r.hist[g]);
		end
	endgenerate

	always_comb begin
		state_nxt = state_r;
		state_nxt.sync1 = rawIn;
		state_nxt.sync2 = state_r.sync1;
		for (int i = 0; i < `GF_WIDTH; i++) begin
			if (`GF_DEPTH > 1)
				state_nxt.hist[i] = history_t'({state_r.hist[i],
					state_r.sync2[i]});
			else
				state_nxt.hist[i] = history_t'(state_r.sync2[i]);
			if (allHigh[i])
				state_nxt.filtOut[i] = 1'h1;
			else if (allLow[i])
				state_nxt.filtOut[i] = 1'h0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			state_r <= {$bits(filter_state_t){`GF_RESET_LEVEL}};
		else
			state_r <= state_nxt;
	end

	assign filtOut = state_r.filtOut;

	// Every lane gets rise and fall checks; lane 0 adds hold, sustain and early-rise, history is checked on lanes 1 and 3
	a_rise_needs_agree: assert property (
		@(posedge clock) disable iff (!rst_n)
		$rose(filtOut[0])
		|->
		$past(allHigh[0])
	) else $error("output rose without unanimous high");

	a_fall_needs_agree: assert property (
		@(posedge clock) disable iff (!rst_n)
		$fell(filtOut[0])
		|->
		$past(allLow[0])
	) else $error("output fell without unanimous low");

	a_rise_lane_one: assert property (
		@(posedge clock) disable iff (!rst_n)
		$rose(filtOut[1])
		|->
		$past(allHigh[1])
	) else $error("lane one rose without unanimous high");

	a_fall_lane_one: assert property (
		@(posedge clock) disable iff (!rst_n)
		$fell(filtOut[1])
		|->
		$past(allLow[1])
	) else $error("lane one fell without unanimous low");

	a_rise_lane_two: assert property (
		@(posedge clock) disable iff (!rst_n)
		$rose(filtOut[2])
		|->
		$past(allHigh[2])
	) else $error("lane two rose without unanimous high");

	a_fall_lane_two: assert property (
		@(posedge clock) disable iff (!rst_n)
		$fell(filtOut[2])
		|->
		$past(allLow[2])
	) else $error("lane two fell without unanimous low");

	a_rise_lane_three: assert property (
		@(posedge clock) disable iff (!rst_n)
		$rose(filtOut[3])
		|->
		$past(allHigh[3])
	) else $error("lane three rose without unanimous high");

	a_fall_lane_three: assert property (
		@(posedge clock) disable iff (!rst_n)
		$fell(filtOut[3])
		|->
		$past(allLow[3])
	) else $error("lane three fell without unanimous low");

	a_hold_on_mixed: assert property (
		@(posedge clock) disable iff (!rst_n)
		!allHigh[0] && !allLow[0]
		|=>
		$stable(filtOut[0])
	) else $error("output moved on mixed samples");

	a_hold_lane_one: assert property (
		@(posedge clock) disable iff (!rst_n)
		!allHigh[1] && !allLow[1]
		|=>
		$stable(filtOut[1])
	) else $error("lane one moved on mixed samples");

	a_hold_lane_three: assert property (
		@(posedge clock) disable iff (!rst_n)
		!allHigh[3] && !allLow[3]
		|=>
		$stable(filtOut[3])
	) else $error("lane three moved on mixed samples");

	a_sustained_high: assert property (
		@(posedge clock) disable iff (!rst_n)
		state_r.sync2[0] [*3]
		|=>
		filtOut[0]
	) else $error("output missed sustained high");

	a_sustained_low: assert property (
		@(posedge clock) disable iff (!rst_n)
		!state_r.sync2[0] [*3]
		|=>
		!filtOut[0]
	) else $error("output missed sustained low");

	a_sustain_high_three: assert property (
		@(posedge clock) disable iff (!rst_n)
		state_r.sync2[3] [*3]
		|=>
		filtOut[3]
	) else $error("lane three missed sustained high");

	a_sustain_low_three: assert property (
		@(posedge clock) disable iff (!rst_n)
		!state_r.sync2[3] [*3]
		|=>
		!filtOut[3]
	) else $error("lane three missed sustained low");

	a_no_early_rise: assert property (
		@(posedge clock) disable iff (!rst_n)
		$rose(filtOut[0])
		|->
		$past(state_r.sync2[0], 3)
	) else $error("output rose before enough samples");

	a_history_shift: assert property (
		@(posedge clock) disable iff (!rst_n)
		1'h1
		|=>
		state_r.hist[1][0] == $past(state_r.sync2[1])
	) else $error("lane history did not shift");

	a_history_depth: assert property (
		@(posedge clock) disable iff (!rst_n)
		1'h1
		|=>
		state_r.hist[3][1] == $past(state_r.hist[3][0])
	) else $error("history did not move to older slot");

	a_sync_chain: assert property (
		@(posedge clock) disable iff (!rst_n)
		1'h1
		|=>
		state_r.sync2 == $past(state_r.sync1)
	) else $error("sample chain broke");

	a_lanes_apart: assert property (
		@(posedge clock) disable iff (!rst_n)
		allHigh[2]
		|=>
		filtOut[2]
	) else $error("lane two ignored its agreement");

	a_reset_zero: assert property (
		@(posedge clock)
		!rst_n
		|->
		filtOut == '0
	) else $error("output not zero in reset");

endmodule

// File: test/gf_line_model.sv
// Line model: raw lanes as a switch or receiver would drive them.
// Assumes the bench sets level just after a rising clock edge.
`include "glitch_filter_params.svh"
module gf_line_model (
	// Clock
	input  wire logic                 clock,
	// Wanted level
	input  wire logic [`GF_WIDTH-1:0] level,
	// Raw lanes
	output logic      [`GF_WIDTH-1:0] rawIn
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rawIn = '0;
	always @(posedge clock) rawIn <= level;
endmodule

// File: test/tb_glitch_filter_n_sample.sv
// Bench for the glitch filter, GF_DEPTH of 2, 4 lanes.
// Assumes 2 sync flops, so a level shows 6 edges after it is set.
`include "glitch_filter_params.svh"
module tb_glitch_filter_n_sample;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 clock = 1'h0;
	logic                 rst_n = 1'h0;
	logic [`GF_WIDTH-1:0] level = '1;
	logic [`GF_WIDTH-1:0] rawIn;
	logic [`GF_WIDTH-1:0] filtOut;
	int                   err_total = 0;
	int                   checks_done = 0;
	int                   cycles = 0;
	always #20 clock = ~clock;
	gf_line_model u_line (.clock(clock), .level(level), .rawIn(rawIn));
	glitch_filter_n_sample u_dut (.clock(clock), .rst_n(rst_n),
		.rawIn(rawIn), .filtOut(filtOut));
	task automatic chk(input logic [`GF_WIDTH-1:0] exp);
		checks_done++;
		if (filtOut !== exp) begin
			err_total++;
			$display("MISMATCH %0t filtOut %h not %h", $time, filtOut, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// High idle lanes give one rising event after reset
	task automatic t_reset();
		step(2);
		chk('0);
		@(posedge clock) rst_n <= 1'h1;
		step(1);
		chk('0);
		step(8);
		chk('1);
	endtask
	// Output moves on the last agreeing sample, not one earlier
	task automatic t_step(input logic [3:0] nv, input logic [3:0] ov);
		@(posedge clock) level <= nv;
		step(5);
		chk(ov);
		step(1);
		chk(nv);
	endtask
	// Two-sample dip on lane 1 is too short for three agreeing samples
	task automatic t_glitch();
		@(posedge clock) level <= 4'hc;
		repeat (2) @(posedge clock);
		level <= 4'he;
		repeat (8) begin
			step(1);
			chk(4'he);
		end
	endtask
	always @(posedge clock) if (++cycles == 200) begin
		err_total++;
		summarize();
	end
	initial begin
		t_reset();
		t_step(4'he, 4'hf);
		t_glitch();
		t_step(4'hf, 4'he);
		summarize();
	end
endmodule
